// File: logic/motion_host_end.sv
// What this block and the sensor end do
// - Motion invalid until 50 ms after reset
// - Sensor reaches low power within 500 us
// - Leave shutdown only through hardware reset
// - Wait 50 ms after shutdown ends
// - Sensor changes output after falling clock
// - Sensor samples input on rising clock
// - Write then next command 45 us
// - Read address to data 35 us
// - Burst exit keeps select high 500 ns
// - Select leads first rising clock 120 ns
// - Write select holds 35 us after clock
// - Read select holds 120 ns after clock
// - Sensor floats output within 500 ns
// - Select and reset are active low
// - Motion pin driven low when pending
// - Serial clock at most 2 MHz, even duty
//
// Host controller: runs one read, write or hardware reset pulse per request, makes the link
// clock by dividing SYS_CLK, and waits out every gap with a counter.
`timescale 1ns/1ps
module motion_host_end #(
    parameter int RESET_VALID_CYCLES = motion_link_pkg::RESET_VALID_CYC
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Requests
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_BURST,
    input wire logic REQ_RESET,
    input wire logic [6:0] REQ_ADDR,
    input wire logic [7:0] REQ_DATA,
    output logic REQ_READY,
    output logic RESP_VALID,
    output logic [7:0] RESP_DATA,
    output logic MOTION_VALID,
    output logic MOTION_PENDING,
    // Link
    motion_link_if.host LINK
);
    import motion_link_pkg::*;

    typedef enum {IDLE, RST_PULSE, LEAD, SHIFT, GAP_AD, HOLD, DESEL, GAP} state_type;

    state_type state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] valid_cnt_reg, valid_cnt_next;
    logic [4:0] div_reg, div_next;
    logic sclk_reg, sclk_next;
    logic cs_n_reg, cs_n_next;
    logic rst_n_reg, rst_n_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] rx_reg, rx_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] bit_reg, bit_next;
    logic data_phase_reg, data_phase_next;
    logic write_reg, write_next;
    logic burst_reg, burst_next;
    logic ready_reg, ready_next;
    logic resp_reg, resp_next;
    logic mvalid_reg, mvalid_next;
    logic [1:0] miso_sync_reg, miso_sync_next;
    logic [1:0] mot_sync_reg, mot_sync_next;
    logic [CNT_W-1:0] post_gap;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    always_comb
    begin
        if (write_reg)
            post_gap = cyc(WRITE_GAP_CYC);
        else if (burst_reg)
            post_gap = cyc(BURST_EXIT_GAP_CYC + READ_NEXT_GAP_CYC);
        else
            post_gap = cyc(READ_NEXT_GAP_CYC);
    end

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        valid_cnt_next = valid_cnt_reg;
        div_next = div_reg;
        sclk_next = sclk_reg;
        cs_n_next = cs_n_reg;
        rst_n_next = rst_n_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        data_next = data_reg;
        bit_next = bit_reg;
        data_phase_next = data_phase_reg;
        write_next = write_reg;
        burst_next = burst_reg;
        ready_next = 1'b0;
        resp_next = 1'b0;
        mvalid_next = mvalid_reg;
        miso_sync_next = {miso_sync_reg[0], LINK.miso_o & LINK.miso_oe};
        mot_sync_next = {mot_sync_reg[0], ~LINK.motion_n};
        if (valid_cnt_reg != '0)
            valid_cnt_next = valid_cnt_reg - 1'b1;
        else
            mvalid_next = 1'b1;
        case (state_reg)
            IDLE:
            begin
                ready_next = 1'b1;
                if (REQ_VALID && ready_reg)
                begin
                    ready_next = 1'b0;
                    write_next = REQ_WRITE;
                    burst_next = REQ_BURST & ~REQ_WRITE;
                    tx_next = {REQ_WRITE, REQ_ADDR};
                    data_next = REQ_DATA;
                    bit_next = 3'h0;
                    data_phase_next = 1'b0;
                    if (REQ_RESET)
                    begin
                        rst_n_next = 1'b0;
                        mvalid_next = 1'b0;
                        cnt_next = cyc(RESET_PULSE_CYC);
                        state_next = RST_PULSE;
                    end
                    else
                    begin
                        cs_n_next = 1'b0;
                        cnt_next = cyc(SELECT_LEAD_CYC);
                        state_next = LEAD;
                    end
                end
            end
            RST_PULSE:
            begin
                // Valid delay stays reloaded for as long as the pulse lasts
                valid_cnt_next = CNT_W'(RESET_VALID_CYCLES);
                mvalid_next = 1'b0;
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == '0)
                begin
                    rst_n_next = 1'b1;
                    state_next = IDLE;
                end
            end
            LEAD:
            begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == '0)
                begin
                    div_next = 5'h0;
                    state_next = SHIFT;
                end
            end
            SHIFT:
            begin
                div_next = div_reg + 5'h1;
                if (div_reg == 5'(SCLK_DIV_HALF - 1))
                begin
                    div_next = 5'h0;
                    sclk_next = ~sclk_reg;
                    if (!sclk_reg)
                    begin
                        rx_next = {rx_reg[6:0], miso_sync_reg[1]};
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == 3'h7)
                        begin
                            if (!data_phase_reg && !write_reg)
                            begin
                                cnt_next = cyc(READ_ADDR_DATA_GAP_CYC);
                                state_next = GAP_AD;
                            end
                            else if (!data_phase_reg)
                            begin
                                data_phase_next = 1'b1;
                            end
                            else
                            begin
                                cnt_next = write_reg ? cyc(DESELECT_LAG_WR_CYC)
                                                     : cyc(DESELECT_LAG_RD_CYC);
                                state_next = HOLD;
                            end
                        end
                    end
                    else if (bit_reg != 3'h0)
                        tx_next = {tx_reg[6:0], 1'b0};
                    // Data byte goes out from the first falling edge of its phase
                    else if (data_phase_reg)
                        tx_next = write_reg ? data_reg : 8'h00;
                end
            end
            GAP_AD:
            begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == '0)
                begin
                    data_phase_next = 1'b1;
                    div_next = 5'h0;
                    state_next = SHIFT;
                end
            end
            HOLD:
            begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == '0)
                begin
                    cs_n_next = 1'b1;
                    state_next = DESEL;
                end
            end
            DESEL:
            begin
                resp_next = ~write_reg;
                data_next = rx_reg;
                cnt_next = post_gap;
                state_next = GAP;
            end
            GAP:
            begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == '0)
                    state_next = IDLE;
            end
            default:
                state_next = IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            state_reg <= IDLE;
            cnt_reg <= '0;
            valid_cnt_reg <= CNT_W'(RESET_VALID_CYCLES);
            div_reg <= 5'h0;
            sclk_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            rst_n_reg <= 1'b1;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            data_reg <= 8'h00;
            bit_reg <= 3'h0;
            data_phase_reg <= 1'b0;
            write_reg <= 1'b0;
            burst_reg <= 1'b0;
            ready_reg <= 1'b0;
            resp_reg <= 1'b0;
            mvalid_reg <= 1'b0;
            miso_sync_reg <= 2'h0;
            mot_sync_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            valid_cnt_reg <= valid_cnt_next;
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            cs_n_reg <= cs_n_next;
            rst_n_reg <= rst_n_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            data_reg <= data_next;
            bit_reg <= bit_next;
            data_phase_reg <= data_phase_next;
            write_reg <= write_next;
            burst_reg <= burst_next;
            ready_reg <= ready_next;
            resp_reg <= resp_next;
            mvalid_reg <= mvalid_next;
            miso_sync_reg <= miso_sync_next;
            mot_sync_reg <= mot_sync_next;
        end
    end

    assign LINK.sclk = sclk_reg;
    assign LINK.cs_n = cs_n_reg;
    assign LINK.mosi = tx_reg[7];
    assign LINK.hw_reset_n = rst_n_reg;
    assign REQ_READY = ready_reg;
    assign RESP_VALID = resp_reg;
    assign RESP_DATA = data_reg;
    assign MOTION_VALID = mvalid_reg;
    assign MOTION_PENDING = mot_sync_reg[1];
endmodule

// File: logic/motion_link_if.sv
// Interface joining the host controller and the sensor end.
// The testbench resolves the tri-state data-out wire from its enable.
`timescale 1ns/1ps
interface motion_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic motion_n;
    logic hw_reset_n;
    modport host (output sclk, output cs_n, output mosi, output hw_reset_n,
                  input miso_o, input miso_oe, input motion_n);
    modport sensor (input sclk, input cs_n, input mosi, input hw_reset_n,
                    output miso_o, output miso_oe, output motion_n);
endinterface

// File: logic/motion_link_pkg.sv
// Shared constants for the motion sensor serial link: timing gaps and
// command encoding. Assumes a 50 MHz system clock on the host side.
package motion_link_pkg;
    localparam int SYS_CLK_MHZ = 50;
    localparam int SCLK_DIV_HALF = 13;
    // Minimum gaps and maximum sensor times, in their own units
    localparam int WRITE_WRITE_GAP_US = 45;
    localparam int WRITE_READ_GAP_US = 45;
    localparam int READ_NEXT_GAP_US = 20;
    localparam int READ_ADDR_DATA_GAP_US = 35;
    localparam int BURST_EXIT_GAP_NS = 500;
    localparam int SELECT_TO_CLOCK_LEAD_NS = 120;
    localparam int CLOCK_TO_DESELECT_LAG_WR_US = 35;
    localparam int CLOCK_TO_DESELECT_LAG_RD_NS = 120;
    localparam int DESELECT_TO_FLOAT_TIME_NS = 500;
    localparam int LOW_POWER_ENTRY_TIME_US = 500;
    localparam int RESET_TO_VALID_DELAY_MS = 50;
    // Cycle counts at 20 ns, minimums rounded up
    localparam int WRITE_GAP_CYC = WRITE_WRITE_GAP_US * SYS_CLK_MHZ;
    localparam int READ_NEXT_GAP_CYC = READ_NEXT_GAP_US * SYS_CLK_MHZ;
    localparam int READ_ADDR_DATA_GAP_CYC = READ_ADDR_DATA_GAP_US * SYS_CLK_MHZ;
    localparam int BURST_EXIT_GAP_CYC = (BURST_EXIT_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SELECT_LEAD_CYC = (SELECT_TO_CLOCK_LEAD_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int DESELECT_LAG_WR_CYC = CLOCK_TO_DESELECT_LAG_WR_US * SYS_CLK_MHZ;
    localparam int DESELECT_LAG_RD_CYC = (CLOCK_TO_DESELECT_LAG_RD_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int RESET_VALID_CYC = RESET_TO_VALID_DELAY_MS * 1000 * SYS_CLK_MHZ;
    localparam int RESET_PULSE_CYC = 16;
    // Device side low-power entry, in 32 ns cycles, rounded down
    localparam int LOW_POWER_ENTRY_CYC = (LOW_POWER_ENTRY_TIME_US * 1000) / 32;
    localparam int CNT_W = 24;
    localparam logic [7:0] WRITE_FLAG = 8'h80;
    localparam logic [6:0] SHUTDOWN_ADDR = 7'h3b;
    localparam logic [6:0] RESET_ADDR = 7'h3a;
    localparam logic [6:0] MOTION_FLAG_ADDR = 7'h02;
    localparam logic [7:0] RESET_VALUE = 8'h00;
endpackage

// File: logic/motion_sensor_end.sv
// Sensor end of the serial link: shifts commands in on the link clock.
// Assumes the host keeps all link timing; motion events come from user side.
`timescale 1ns/1ps
module motion_sensor_end (
    // Link
    motion_link_if.sensor LINK,
    // User side
    input wire logic MOTION_EVENT,
    input wire logic [7:0] READ_DATA,
    output logic [7:0] WRITE_ADDR,
    output logic [7:0] WRITE_DATA,
    output logic WRITE_TOGGLE,
    output logic LOW_POWER
);
    import motion_link_pkg::*;

    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_reg, bit_next;
    logic addr_phase_reg, addr_phase_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wtog_reg, wtog_next;
    logic [7:0] out_reg, out_next;
    logic shutdown_reg, shutdown_next;
    logic lp_reg, lp_next;
    logic motion_reg, motion_next;

    // Rising-edge capture of the command and data bytes
    always_comb
    begin
        shift_next = shift_reg;
        bit_next = bit_reg;
        addr_phase_next = addr_phase_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        wtog_next = wtog_reg;
        shutdown_next = shutdown_reg;
        motion_next = motion_reg | MOTION_EVENT;
        if (LINK.cs_n)
        begin
            bit_next = 4'h0;
            addr_phase_next = 1'b1;
        end
        else
        begin
            shift_next = {shift_reg[6:0], LINK.mosi};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7)
            begin
                bit_next = 4'h0;
                if (addr_phase_reg)
                begin
                    addr_next = {shift_reg[6:0], LINK.mosi};
                    addr_phase_next = 1'b0;
                    // A read of the flag address clears it; a new event still wins
                    if ({shift_reg[6:0], LINK.mosi} == {1'b0, MOTION_FLAG_ADDR})
                        motion_next = MOTION_EVENT;
                end
                else
                begin
                    wdata_next = {shift_reg[6:0], LINK.mosi};
                    addr_phase_next = 1'b1;
                    if (addr_reg[7])
                    begin
                        wtog_next = ~wtog_reg;
                        if (addr_reg[6:0] == SHUTDOWN_ADDR)
                            shutdown_next = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge LINK.sclk or negedge LINK.hw_reset_n)
    begin
        if (!LINK.hw_reset_n)
        begin
            shift_reg <= 8'h00;
            bit_reg <= 4'h0;
            addr_phase_reg <= 1'b1;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wtog_reg <= 1'b0;
            shutdown_reg <= 1'b0;
            motion_reg <= 1'b0;
        end
        else
        begin
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            addr_phase_reg <= addr_phase_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            wtog_reg <= wtog_next;
            shutdown_reg <= shutdown_next;
            motion_reg <= motion_next;
        end
    end

    // Falling-edge launch of read data
    always_comb
    begin
        out_next = out_reg;
        if (!LINK.cs_n)
        begin
            if (bit_reg == 4'h0 && !addr_phase_reg)
                out_next = READ_DATA;
            else
                out_next = {out_reg[6:0], 1'b0};
        end
    end

    always_ff @(negedge LINK.sclk or negedge LINK.hw_reset_n)
    begin
        if (!LINK.hw_reset_n)
            out_reg <= 8'h00;
        else
            out_reg <= out_next;
    end

    // Low-power entry with the shutdown write itself: the link clock
    // stops between frames, so no count on it could ever run out
    always_comb
    begin
        lp_next = lp_reg | shutdown_next;
    end

    always_ff @(posedge LINK.sclk or negedge LINK.hw_reset_n)
    begin
        if (!LINK.hw_reset_n)
            lp_reg <= 1'b0;
        else
            lp_reg <= lp_next;
    end

    assign LINK.miso_o = out_reg[7];
    assign LINK.miso_oe = ~LINK.cs_n & ~lp_reg;
    assign LINK.motion_n = ~motion_reg;
    assign WRITE_ADDR = addr_reg;
    assign WRITE_DATA = wdata_reg;
    assign WRITE_TOGGLE = wtog_reg;
    assign LOW_POWER = lp_reg;
endmodule

// File: sim/motion_sensor_spi_timing_asserts.sv
// Timing checker for the motion sensor serial link.
// Assumes it sits beside the interface and sees SYS_CLK, RST and the link signals.
`timescale 1ns/1ps
module motion_sensor_spi_timing_asserts (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic motion_n,
    input wire logic hw_reset_n
);
    logic sclk_reg;
    logic wr_reg;
    logic last_wr_reg;
    logic [4:0] stable_reg;
    logic [4:0] rise_reg;
    logic [4:0] high_reg;
    logic [11:0] since_reg;
    logic [11:0] gap_reg;
    logic rise;
    logic turn;
    logic last_rise;

    assign rise = sclk && !sclk_reg && !cs_n;
    assign turn = (sclk != sclk_reg) && !cs_n;
    assign last_rise = rise && (rise_reg == 5'h0f);

    // Frame bookkeeping: rising edges seen, cycles since the last rising edge and the last frame
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            sclk_reg <= 1'b1;
            wr_reg <= 1'b0;
            last_wr_reg <= 1'b0;
            stable_reg <= 5'h1f;
            rise_reg <= 5'h00;
            high_reg <= 5'h1f;
            since_reg <= 12'hfff;
            gap_reg <= 12'hfff;
        end
        else
        begin
            sclk_reg <= sclk;
            stable_reg <= (sclk != sclk_reg) ? 5'h00 : stable_reg + {4'h0, stable_reg != 5'h1f};
            rise_reg <= cs_n ? 5'h00 : rise_reg + {4'h0, rise};
            if (rise && rise_reg == 5'h00)
                wr_reg <= mosi;
            if (last_rise)
                last_wr_reg <= wr_reg;
            since_reg <= rise ? 12'h000 : since_reg + {11'h0, since_reg != 12'hfff};
            gap_reg <= last_rise ? 12'h000 : gap_reg + {11'h0, gap_reg != 12'hfff};
            high_reg <= !cs_n ? 5'h00 : high_reg + {4'h0, high_reg != 5'h1f};
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    sequence clock_quiet;
        sclk [*6];
    endsequence
    sequence low8;
        !hw_reset_n [*8];
    endsequence

    a_select_lead_clock: assert property ($fell(cs_n) |-> clock_quiet)
        else $error("sclk moved too soon after select");
    a_data_setup: assert property ((!cs_n && !$fell(cs_n) && $changed(mosi)) |-> !sclk)
        else $error("mosi changed while sclk high");
    a_clock_half_period: assert property (turn |-> stable_reg >= 5'h0c)
        else $error("sclk phase shorter than 13 cycles");
    a_output_float: assert property ($rose(cs_n) |-> ##[0:25] !miso_oe)
        else $error("miso still driven after deselect");
    a_output_after_fall: assert property ((!cs_n && !$past(cs_n) && $changed(miso_o))
        |-> !sclk)
        else $error("miso changed while sclk high");
    a_addr_data_gap: assert property ((turn && !sclk && rise_reg == 5'h08 && !wr_reg)
        |-> since_reg >= 12'h6d5)
        else $error("read data clocked too soon after address");
    a_write_hold: assert property (($rose(cs_n) && rise_reg == 5'h10 && wr_reg)
        |-> since_reg >= 12'h6d5)
        else $error("write select released too early");
    a_read_hold: assert property (($rose(cs_n) && rise_reg == 5'h10 && !wr_reg)
        |-> since_reg >= 12'h005)
        else $error("read select released too early");
    a_write_gap: assert property ((rise && last_wr_reg && ((rise_reg == 5'h0f && wr_reg)
        || (rise_reg == 5'h07 && !wr_reg))) |-> gap_reg >= 12'h8c9)
        else $error("command too soon after write");
    a_read_gap: assert property ((rise && rise_reg == 5'h00 && !last_wr_reg)
        |-> gap_reg >= 12'h3e7)
        else $error("command too soon after read");
    a_deselect_time: assert property ($fell(cs_n) |-> high_reg >= 5'h19)
        else $error("select high too briefly between frames");
    a_reset_pulse: assert property ($fell(hw_reset_n) |-> low8 ##1 low8 ##1 hw_reset_n)
        else $error("hardware reset pulse not 16 cycles");
endmodule

// File: sim/tb_motion_sensor_spi_timing.sv
// Testbench joining host and sensor ends through the link interface.
// Assumes a 50 MHz SYS_CLK and a shortened reset-valid delay of 100 cycles.
`timescale 1ns/1ps
module tb_motion_sensor_spi_timing;
    import motion_link_pkg::*;
    typedef struct packed {
        logic wr;
        logic burst;
        logic [6:0] addr;
        logic [7:0] data;
    } row_type;
    localparam int ROWS = 7;
    localparam int WAIT_MAX = 20000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_burst = 1'b0;
    logic req_reset = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_data = 8'h00;
    logic motion_event = 1'b0;
    logic [7:0] read_data = 8'h00;
    logic req_ready, resp_valid, motion_valid, motion_pending, write_toggle, low_power;
    logic [7:0] resp_data, write_addr, write_data, got_data;
    logic got_resp, miso_line;
    logic [15:0] mosi_sh = 16'h0000;
    logic [15:0] miso_sh = 16'h0000;
    logic [4:0] rise_cnt = 5'h00;
    int errors = 0;
    int compares = 0;
    // Back-to-back writes, write then read, read then read, read then write, burst
    row_type rows [ROWS] = '{'{1'b1, 1'b0, 7'h15, 8'ha5}, '{1'b1, 1'b0, 7'h15, 8'h5a},
        '{1'b0, 1'b0, 7'h00, 8'h3c}, '{1'b0, 1'b0, 7'h7f, 8'hff}, '{1'b1, 1'b0, 7'h7f, 8'h00},
        '{1'b0, 1'b1, 7'h16, 8'h81}, '{1'b0, 1'b0, 7'h01, 8'h00}};

    motion_link_if link();
    assign miso_line = link.miso_oe ? link.miso_o : 1'bz;

    motion_host_end #(.RESET_VALID_CYCLES(100)) u_motion_host_end (
        .SYS_CLK(sys_clk), .RST(rst), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_BURST(req_burst), .REQ_RESET(req_reset), .REQ_ADDR(req_addr),
        .REQ_DATA(req_data), .REQ_READY(req_ready), .RESP_VALID(resp_valid),
        .RESP_DATA(resp_data), .MOTION_VALID(motion_valid),
        .MOTION_PENDING(motion_pending), .LINK(link));
    motion_sensor_end u_motion_sensor_end (
        .LINK(link), .MOTION_EVENT(motion_event), .READ_DATA(read_data),
        .WRITE_ADDR(write_addr), .WRITE_DATA(write_data), .WRITE_TOGGLE(write_toggle),
        .LOW_POWER(low_power));
    motion_sensor_spi_timing_asserts u_motion_sensor_spi_timing_asserts (
        .SYS_CLK(sys_clk), .RST(rst), .sclk(link.sclk), .cs_n(link.cs_n),
        .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
        .motion_n(link.motion_n), .hw_reset_n(link.hw_reset_n));

    always #10 sys_clk = ~sys_clk;

    // Wire monitor: bits as the sensor sees them on each rising sclk
    always @(posedge link.sclk)
    begin
        if (link.cs_n === 1'b0)
        begin
            mosi_sh = {mosi_sh[14:0], link.mosi};
            miso_sh = {miso_sh[14:0], miso_line};
            rise_cnt = rise_cnt + 5'h01;
        end
    end
    always @(negedge link.cs_n)
        rise_cnt = 5'h00;

    task final_report;
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask

    task check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask

    task send_req(input logic wr, input logic burst, input logic rq, input logic [6:0] addr,
        input logic [7:0] data);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < WAIT_MAX)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= WAIT_MAX)
        begin
            errors++;
            $display("unexpected at %0t: request never accepted", $time);
        end
        req_valid = 1'b1;
        req_write = wr;
        req_burst = burst;
        req_reset = rq;
        req_addr = addr;
        req_data = data;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
    endtask

    task wait_done;
        int n;
        n = 0;
        got_resp = 1'b0;
        do
        begin
            @(posedge sys_clk);
            #1;
            if (resp_valid === 1'b1)
            begin
                got_resp = 1'b1;
                got_data = resp_data;
            end
            n++;
        end
        while (req_ready !== 1'b1 && n < WAIT_MAX);
        if (n >= WAIT_MAX)
        begin
            errors++;
            $display("unexpected at %0t: transfer never completed", $time);
        end
    endtask

    task xfer(input row_type r);
        logic tog;
        tog = write_toggle;
        read_data = r.data;
        send_req(r.wr, r.burst, 1'b0, r.addr, r.data);
        wait_done;
        check_byte(mosi_sh[15:8], {r.wr, r.addr});
        check_byte({3'h0, rise_cnt}, 8'h10);
        if (r.wr)
        begin
            check_byte(write_data, r.data);
            check_byte({1'b0, write_addr[6:0]}, {1'b0, r.addr});
            check_bit(write_toggle, ~tog);
        end
        else
        begin
            check_bit(got_resp, 1'b1);
            check_byte(got_data, r.data);
            check_byte(miso_sh[7:0], r.data);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1;
        check_bit(link.cs_n, 1'b1);
        check_bit(link.sclk, 1'b1);
        check_bit(link.hw_reset_n, 1'b1);
        check_bit(req_ready, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check_bit(motion_valid, 1'b0);
        send_req(1'b0, 1'b0, 1'b1, 7'h00, 8'h00);
        repeat (4) @(posedge sys_clk);
        #1;
        check_bit(link.hw_reset_n, 1'b0);
        check_bit(motion_valid, 1'b0);
        wait_done;
        repeat (90) @(posedge sys_clk);
        #1;
        check_bit(motion_valid, 1'b0);
        repeat (40) @(posedge sys_clk);
        #1;
        check_bit(motion_valid, 1'b1);
        check_byte(write_data, 8'h00);
        check_bit(low_power, 1'b0);
        check_bit(link.motion_n, 1'b1);
        for (int i = 0; i < ROWS; i++)
            xfer(rows[i]);
        // Motion seen during a frame, then cleared by reading its flag address
        motion_event = 1'b1;
        xfer('{1'b1, 1'b0, 7'h15, 8'h0f});
        motion_event = 1'b0;
        check_bit(link.motion_n, 1'b0);
        check_bit(motion_pending, 1'b1);
        xfer('{1'b0, 1'b0, MOTION_FLAG_ADDR, 8'h80});
        xfer('{1'b1, 1'b0, 7'h15, 8'hf0});
        check_bit(motion_pending, 1'b0);
        // Shutdown, then the hardware reset that alone wakes the sensor
        xfer('{1'b1, 1'b0, SHUTDOWN_ADDR, 8'h00});
        check_bit(low_power, 1'b1);
        check_bit(link.miso_oe, 1'b0);
        send_req(1'b0, 1'b0, 1'b1, 7'h00, 8'h00);
        wait_done;
        check_bit(low_power, 1'b0);
        check_bit(motion_valid, 1'b0);
        repeat (130) @(posedge sys_clk);
        #1;
        check_bit(motion_valid, 1'b1);
        final_report;
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        final_report;
    end
endmodule
